// ==== logic/hpd_pkg.sv ====
package hpd_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	// register indices of the small register set behind the port
	localparam logic [4:0] REG_STATUS = 5'h00;
	localparam logic [4:0] REG_CTRL = 5'h01;
	localparam logic [4:0] REG_SCRATCH = 5'h02;
	// status field positions
	localparam int ST_FREE = 0;
	localparam int ST_WASFREE = 1;
	localparam int ST_EXTPLL = 2;
	localparam int ST_MODE = 3;
	// writing this bit of the status register clears the sticky flag
	localparam int CLR_WASFREE = 1;
	// wait states inserted per access in the ready variant
	localparam int WAIT_CYC = 2;
	// phase reference divider and internal pll step size
	localparam int PHASE_DIV = 16;
	localparam logic [15:0] NCO_STEP = 16'h1000;
	localparam logic [15:0] NCO_TRIM = 16'h0010;
	localparam logic [15:0] RST_SCRATCH = 16'h0000;
endpackage

// ==== logic/hpd_if.sv ====
`timescale 1ns/1ps
interface hpd_if;
	logic mode_sel;
	logic [4:0] addr;
	logic cs_n;
	logic wr_n;
	logic rd_n;
	logic ready_n;
	logic [15:0] data_host;
	logic data_host_oe_n;
	logic [15:0] data_dev;
	logic data_dev_oe_n;
	logic [15:0] data_bus;
	// resolved bus level: whichever end enables drives, else pulled high
	assign data_bus = !data_dev_oe_n ? data_dev : (!data_host_oe_n ? data_host : 16'hffff);
	modport dev (input mode_sel, addr, cs_n, wr_n, rd_n, data_bus,
		output ready_n, data_dev, data_dev_oe_n);
	modport host (output mode_sel, addr, cs_n, wr_n, rd_n, data_host, data_host_oe_n,
		input ready_n, data_bus);
endinterface

// ==== logic/hpd_dev.sv ====
`timescale 1ns/1ps
module hpd_dev #(
	parameter int WAIT_CYC = hpd_pkg::WAIT_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst,
	hpd_if.dev bus,
	input wire logic i_pll_inc,
	input wire logic i_pll_dec,
	input wire logic i_pll_free,
	output logic o_phase_ref,
	output logic o_ext_pll,
	output logic o_free,
	output logic o_wasfree,
	output logic [15:0] o_nco_step
);
	localparam int DIV_W = $clog2(hpd_pkg::PHASE_DIV);
	// strap and free-wheel state
	logic ext_pll_reg;
	logic free_reg;
	logic wasfree_reg;

	// host-visible registers and read path
	logic [15:0] ctrl_reg;
	logic [15:0] scratch_reg;
	logic [15:0] rdata_reg;
	logic [15:0] status_word;
	logic [3:0] wcnt_reg;

	// internal pll and its phase reference
	logic [15:0] nco_reg;
	logic [15:0] step_reg;
	logic [DIV_W-1:0] div_reg;
	logic phase_en;
	logic phase_reg;

	// bus decode and handshake
	logic sel;
	logic wr_req;
	logic rd_req;
	logic wr_prev_reg;
	logic wr_pulse;
	logic clr_wasfree;
	logic ready_var;

	// access decode from the host strobes; nothing is decoded while unselected
	assign sel = !bus.cs_n;
	assign wr_req = sel && !bus.wr_n;
	assign rd_req = sel && !bus.rd_n;
	assign wr_pulse = wr_req && !wr_prev_reg;
	assign ready_var = bus.mode_sel;

	// sticky clear: a one written to its status bit, once per write strobe
	assign clr_wasfree = wr_pulse && bus.addr == hpd_pkg::REG_STATUS
		&& bus.data_bus[hpd_pkg::CLR_WASFREE];

	// strap capture: sample the increment pin on every reset cycle, hold after
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ext_pll_reg <= i_pll_inc;
		end
	end

	// write edge detect so a long strobe writes once
	// a strobe held through wait states must not store or clear twice
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_prev_reg <= 1'b0;
		end else begin
			wr_prev_reg <= wr_req;
		end
	end

	// free-wheel flags, set beats clear on the sticky flag
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			free_reg <= 1'b0;
			wasfree_reg <= 1'b0;
		end else begin
			free_reg <= ext_pll_reg && i_pll_free;
			if (ext_pll_reg && i_pll_free) begin
				wasfree_reg <= 1'b1;
			end else if (clr_wasfree) begin
				wasfree_reg <= 1'b0;
			end
		end
	end

	// host writes to control and scratch registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctrl_reg <= hpd_pkg::NCO_STEP;
			scratch_reg <= hpd_pkg::RST_SCRATCH;
		end else if (wr_pulse) begin
			case (bus.addr)
				hpd_pkg::REG_CTRL: ctrl_reg <= bus.data_bus;
				hpd_pkg::REG_SCRATCH: scratch_reg <= bus.data_bus;
				default: ;
			endcase
		end
	end

	// internal pll step: the control value, nudged by one trim while the
	// external pll holds increment or decrement; both at once cancel
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			step_reg <= hpd_pkg::NCO_STEP;
		end else if (ext_pll_reg && i_pll_dec && !i_pll_inc) begin
			step_reg <= ctrl_reg - hpd_pkg::NCO_TRIM;
		end else if (ext_pll_reg && i_pll_inc && !i_pll_dec) begin
			step_reg <= ctrl_reg + hpd_pkg::NCO_TRIM;
		end else begin
			step_reg <= ctrl_reg;
		end
	end

	// divider: one-cycle enable every PHASE_DIV clocks paces the accumulator
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + DIV_W'(1);
		end
	end
	assign phase_en = div_reg == '0;

	// phase accumulator; stepping only on the enable keeps its msb from
	// aliasing against the divider at the nominal step
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			nco_reg <= 16'h0000;
		end else if (phase_en) begin
			nco_reg <= nco_reg + step_reg;
		end
	end

	// phase reference follows the accumulator msb every clock
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			phase_reg <= 1'b0;
		end else begin
			phase_reg <= nco_reg[15];
		end
	end

	// wait-state counter restarts on every new access
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wcnt_reg <= 4'h0;
		end else if (!(rd_req || wr_req)) begin
			wcnt_reg <= 4'(WAIT_CYC);
		end else if (wcnt_reg != 4'h0) begin
			wcnt_reg <= wcnt_reg - 4'h1;
		end
	end

	// status word assembled from the live flags and straps
	always_comb begin
		status_word = 16'h0000;
		status_word[hpd_pkg::ST_FREE] = free_reg;
		status_word[hpd_pkg::ST_WASFREE] = wasfree_reg;
		status_word[hpd_pkg::ST_EXTPLL] = ext_pll_reg;
		status_word[hpd_pkg::ST_MODE] = ready_var;
	end

	// read data mux, registered
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rdata_reg <= 16'h0000;
		end else begin
			case (bus.addr)
				hpd_pkg::REG_STATUS: rdata_reg <= status_word;
				hpd_pkg::REG_CTRL: rdata_reg <= ctrl_reg;
				hpd_pkg::REG_SCRATCH: rdata_reg <= scratch_reg;
				default: rdata_reg <= 16'h0000;
			endcase
		end
	end

	// ready low while waits remain in variant one, high otherwise
	assign bus.ready_n = !(ready_var && (rd_req || wr_req) && wcnt_reg != 4'h0);

	// read data drives the bus only during a selected read, so a write never collides
	assign bus.data_dev = rdata_reg;
	assign bus.data_dev_oe_n = !rd_req;

	// registered status and pll outputs
	assign o_phase_ref = phase_reg;
	assign o_ext_pll = ext_pll_reg;
	assign o_free = free_reg;
	assign o_wasfree = wasfree_reg;
	assign o_nco_step = step_reg;
endmodule // hpd_dev

// ==== logic/hpd_host.sv ====
`timescale 1ns/1ps
module hpd_host #(
	parameter int HOLD_CYC = 3
) (
	input wire logic i_clk,
	input wire logic i_rst,
	hpd_if.host bus,
	input wire logic i_mode,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [4:0] i_addr,
	input wire logic [15:0] i_wdata,
	output logic o_busy,
	output logic o_done,
	output logic [15:0] o_rdata
);
	typedef enum logic [1:0] {
		HPD_IDLE = 2'b00,
		HPD_STRB = 2'b01,
		HPD_END = 2'b10
	} hpd_state_t;
	hpd_state_t st_reg;
	logic we_reg;
	logic [4:0] addr_reg;
	logic [15:0] wdata_reg;
	logic [15:0] rdata_reg;
	logic [3:0] cnt_reg;
	logic done_reg;

	// access sequencer: strobe held a minimum time, then in variant one until ready is high
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= HPD_IDLE;
			cnt_reg <= 4'h0;
			done_reg <= 1'b0;
			we_reg <= 1'b0;
			addr_reg <= 5'h00;
			wdata_reg <= 16'h0000;
			rdata_reg <= 16'h0000;
		end else begin
			done_reg <= 1'b0;
			case (st_reg)
				HPD_IDLE: begin
					if (i_req) begin
						we_reg <= i_we;
						addr_reg <= i_addr;
						wdata_reg <= i_wdata;
						cnt_reg <= 4'(HOLD_CYC);
						st_reg <= HPD_STRB;
					end
				end
				HPD_STRB: begin
					if (cnt_reg != 4'h0) begin
						cnt_reg <= cnt_reg - 4'h1;
					end else if (!i_mode || bus.ready_n) begin
						rdata_reg <= bus.data_bus;
						st_reg <= HPD_END;
					end
				end
				HPD_END: begin
					done_reg <= 1'b1;
					st_reg <= HPD_IDLE;
				end
				default: st_reg <= HPD_IDLE;
			endcase
		end
	end

	assign bus.mode_sel = i_mode;
	assign bus.addr = addr_reg;
	assign bus.cs_n = st_reg != HPD_STRB;
	assign bus.wr_n = !(st_reg == HPD_STRB && we_reg);
	assign bus.rd_n = !(st_reg == HPD_STRB && !we_reg);
	assign bus.data_host = wdata_reg;
	assign bus.data_host_oe_n = !(st_reg == HPD_STRB && we_reg);
	assign o_busy = st_reg != HPD_IDLE;
	assign o_done = done_reg;
	assign o_rdata = rdata_reg;
endmodule // hpd_host

// ==== sim/hpd_props.sv ====
`timescale 1ns/1ps
module hpd_props (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic mode_sel,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic ready_n,
	input wire logic data_dev_oe_n
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// strobe of a selected access
	logic stb;
	assign stb = !cs_n && !(wr_n && rd_n);
	chk_ready_zero: assert property (!mode_sel |-> ready_n)
		else $error("ready low in variant zero");
	chk_wait_start: assert property (mode_sel && stb && !$past(stb) |-> !ready_n [*2] ##1 ready_n)
		else $error("wait states wrong");
	chk_ready_idle: assert property (mode_sel && !stb |-> ready_n)
		else $error("ready low while idle");
	chk_ready_bound: assert property (!ready_n |-> ##[1:2] ready_n)
		else $error("wait too long");
	chk_nocs_ready: assert property (cs_n |-> ready_n)
		else $error("ready low unselected");
	chk_read_drive: assert property (!cs_n && !rd_n |-> !data_dev_oe_n)
		else $error("read not driven");
	chk_bus_release: assert property (cs_n || rd_n |-> data_dev_oe_n)
		else $error("bus driven unselected");
	chk_write_quiet: assert property (!cs_n && !wr_n |-> data_dev_oe_n)
		else $error("bus driven on write");
endmodule // hpd_props

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
	logic i_clk = 0, i_rst = 1, inc = 0, dec = 0, free = 0, mode = 0, req = 0, we = 0;
	logic pref, ext, f, wf, busy, done;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000, rdata, step;
	int error_cnt = 0, checks = 0;
	// free running clock
	always #2 i_clk = ~i_clk;
	hpd_if hpd_if_i();
	hpd_dev hpd_dev_i(.i_clk(i_clk), .i_rst(i_rst), .bus(hpd_if_i.dev), .i_pll_inc(inc),
		.i_pll_dec(dec), .i_pll_free(free), .o_phase_ref(pref), .o_ext_pll(ext),
		.o_free(f), .o_wasfree(wf), .o_nco_step(step));
	hpd_host hpd_host_i(.i_clk(i_clk), .i_rst(i_rst), .bus(hpd_if_i.host), .i_mode(mode),
		.i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wdata), .o_busy(busy),
		.o_done(done), .o_rdata(rdata));
	hpd_props hpd_props_i(.i_clk(i_clk), .i_rst(i_rst), .mode_sel(hpd_if_i.mode_sel),
		.cs_n(hpd_if_i.cs_n), .wr_n(hpd_if_i.wr_n), .rd_n(hpd_if_i.rd_n),
		.ready_n(hpd_if_i.ready_n), .data_dev_oe_n(hpd_if_i.data_dev_oe_n));
	// reset with the pll strap level held on the increment pin
	task automatic rst(input logic s);
		@(negedge i_clk);
		i_rst = 1;
		inc = s;
		repeat (2) @(negedge i_clk);
		i_rst = 0;
		inc = 0;
	endtask
	// one host access, waits for completion under a bound
	task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
		int n;
		logic lo;
		n = 0;
		lo = 1'b0;
		@(negedge i_clk);
		we = w;
		addr = a;
		wdata = d;
		req = 1;
		@(negedge i_clk);
		req = 0;
		`CHK({busy, hpd_if_i.cs_n}, 2'b10)
		while (done !== 1'b1 && n < 40) begin
			lo = lo | !hpd_if_i.ready_n;
			@(negedge i_clk);
			n++;
		end
		`CHK(done, 1'b1)
		`CHK(lo, mode)
	endtask
	// both bus variants, mapped and unmapped places
	task automatic s_rw();
		for (int m = 0; m < 2; m++) begin
			mode = m[0];
			acc(1, hpd_pkg::REG_SCRATCH, 16'ha5c3 ^ 16'(m));
			acc(1, 5'h12, 16'hffff);
			acc(0, hpd_pkg::REG_SCRATCH, 16'h0000);
			`CHK(rdata, 16'ha5c3 ^ 16'(m))
			acc(0, 5'h12, 16'h0000);
			`CHK(rdata, 16'h0000)
			acc(0, hpd_pkg::REG_STATUS, 16'h0000);
			`CHK(rdata[3], m[0])
		end
	endtask
	// external pll strapped: flags and trim
	task automatic s_ext();
		rst(1'b1);
		`CHK(ext, 1'b1)
		free = 1;
		repeat (3) @(negedge i_clk);
		`CHK({f, wf}, 2'b11)
		free = 0;
		repeat (3) @(negedge i_clk);
		`CHK({f, wf}, 2'b01)
		acc(0, hpd_pkg::REG_STATUS, 16'h0000);
		`CHK(rdata[2:0], 3'b110)
		acc(1, hpd_pkg::REG_STATUS, 16'h0001 << hpd_pkg::CLR_WASFREE);
		`CHK(wf, 1'b0)
		inc = 1;
		repeat (4) @(negedge i_clk);
		inc = 0;
		`CHK(step > hpd_pkg::NCO_STEP, 1'b1)
		dec = 1;
		repeat (4) @(negedge i_clk);
		dec = 0;
		`CHK(step < hpd_pkg::NCO_STEP, 1'b1)
	endtask
	// no external pll: free and increment inputs have no effect
	task automatic s_int();
		rst(1'b0);
		@(negedge i_clk);
		free = 1;
		inc = 1;
		repeat (3) @(negedge i_clk);
		`CHK({ext, f, wf}, 3'b000)
		`CHK(step, hpd_pkg::NCO_STEP)
		free = 0;
		inc = 0;
	endtask
	// phase reference half period at the nominal step, no pll nudges
	task automatic s_phase();
		logic p;
		int n;
		n = 0;
		p = pref;
		while (pref === p && n < 400) begin
			@(negedge i_clk);
			n++;
		end
		p = pref;
		n = 0;
		while (pref === p && n < 400) begin
			@(negedge i_clk);
			n++;
		end
		`CHK(n, hpd_pkg::PHASE_DIV * (32'h8000 / 32'(hpd_pkg::NCO_STEP)))
	endtask
	task automatic final_report();
		if (error_cnt == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge i_clk);
		i_rst = 0;
		s_rw();
		s_ext();
		s_int();
		s_phase();
		final_report();
	end
	// watchdog
	initial begin
		#20000;
		error_cnt++;
		final_report();
	end
endmodule // tb_top
